/* File: verilog/lpd_ctrl.sv */
// Purpose: Legacy port positive decode and write posting / burst control
// Assumes: Primary address phase presented as a one-cycle valid strobe
// Notes:   Registers over AXI4-Lite; posting handled per interface
//
// Chosen here: register access over AXI4-Lite.

`timescale 1ns/10ps

// Notes on behaviour
// - Enable byte resets zero, top bit reserved
// - Third parallel port ranges decoded when enabled
// - Second parallel port ranges decoded when enabled
// - First parallel port ranges decoded when enabled
// - Fourth serial port range decoded when enabled
// - Third serial port range decoded when enabled
// - Second serial port range decoded when enabled
// - First serial port range decoded when enabled
// - Forwarding also needs matching map bit
// - Cleared map bit leaves range unclaimed
// - Buffer byte resets 07h, top three reserved
// - Buffer bit 3 reserved, reads zero
// - Bit 4 selects multi-line upstream read bursts
// - Bit 2 enables downstream prefetchable bursting
// - Bit 1 enables primary side write posting
// - Primary posting off drains buffers first
// - Bit 0 same for secondary side posting
// - Unposted: one word per target acceptance
// - Enable byte at 58h, buffer at 59h
module lpd_ctrl
(
	// Clock and reset
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_nrst,
	// AXI4-Lite slave
	input  wire logic [lpd_pkg::ADDR_W-1:0] i_s_axi_awaddr,
	input  wire logic                       i_s_axi_awvalid,
	output logic                            o_s_axi_awready,
	input  wire logic [31:0]                i_s_axi_wdata,
	input  wire logic [3:0]                 i_s_axi_wstrb,
	input  wire logic                       i_s_axi_wvalid,
	output logic                            o_s_axi_wready,
	output logic [1:0]                      o_s_axi_bresp,
	output logic                            o_s_axi_bvalid,
	input  wire logic                       i_s_axi_bready,
	input  wire logic [lpd_pkg::ADDR_W-1:0] i_s_axi_araddr,
	input  wire logic                       i_s_axi_arvalid,
	output logic                            o_s_axi_arready,
	output logic [31:0]                     o_s_axi_rdata,
	output logic [1:0]                      o_s_axi_rresp,
	output logic                            o_s_axi_rvalid,
	input  wire logic                       i_s_axi_rready,
	// Primary bus address phase
	input  wire logic                       i_pri_addr_vld,
	input  wire logic [3:0]                 i_pri_cmd,
	input  wire logic [31:0]                i_pri_addr,
	input  wire logic                       i_io_window_hit,
	output logic                            o_pri_claim,
	output logic                            o_fwd_secondary,
	output logic [lpd_pkg::NUM_PORTS-1:0]   o_port_hit,
	// Burst control
	output logic                            o_up_burst_multi,
	output logic                            o_dn_burst_en,
	// Write posting, index 0 secondary side, index 1 primary side
	input  wire logic [lpd_pkg::NUM_IFC-1:0] i_buf_empty,
	input  wire logic [lpd_pkg::NUM_IFC-1:0] i_src_valid,
	input  wire logic [lpd_pkg::NUM_IFC-1:0] i_src_last,
	input  wire logic [lpd_pkg::NUM_IFC-1:0] i_tgt_accept,
	output logic [lpd_pkg::NUM_IFC-1:0]      o_post_en,
	output logic [lpd_pkg::NUM_IFC-1:0]      o_src_take,
	output logic [lpd_pkg::NUM_IFC-1:0]      o_master_release,
	output logic [lpd_pkg::NUM_IFC-1:0]      o_draining
);
	import lpd_pkg::*;

	logic [7:0]            port_en;
	logic [7:0]            buf_ctl;
	logic [7:0]            port_map;
	logic [7:0]            chip_ctl;
	logic [NUM_PORTS-1:0]  last_hit;

	logic                  aw_hold;
	logic                  w_hold;
	logic [ADDR_W-1:0]     aw_addr;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;
	logic                  do_write;
	logic                  wr_hit;
	logic [31:0]           rd_word;
	logic                  rd_hit;

	logic [NUM_PORTS-1:0]  range_match;
	logic [NUM_PORTS-1:0]  next_hit;
	logic                  io_cmd;

	// Write channel: address and data taken in either order
	assign o_s_axi_awready = ~aw_hold & ~o_s_axi_bvalid;
	assign o_s_axi_wready  = ~w_hold & ~o_s_axi_bvalid;
	assign do_write        = aw_hold & w_hold & ~o_s_axi_bvalid;
	assign wr_hit = (aw_addr == lpd_byte_addr(IDX_PORT_EN)) ||
		(aw_addr == lpd_byte_addr(IDX_BUF_CTL)) ||
		(aw_addr == lpd_byte_addr(IDX_PORT_MAP)) ||
		(aw_addr == lpd_byte_addr(IDX_CHIP_CTL)) ||
		(aw_addr == lpd_byte_addr(IDX_STATUS));

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			aw_hold <= 1'b0;
			aw_addr <= '0;
		end
		else if (i_s_axi_awvalid && o_s_axi_awready)
		begin
			aw_hold <= 1'b1;
			aw_addr <= i_s_axi_awaddr;
		end
		else if (do_write)
			aw_hold <= 1'b0;
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			w_hold <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end
		else if (i_s_axi_wvalid && o_s_axi_wready)
		begin
			w_hold <= 1'b1;
			w_data <= i_s_axi_wdata;
			w_strb <= i_s_axi_wstrb;
		end
		else if (do_write)
			w_hold <= 1'b0;
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp  <= RESP_OKAY;
		end
		else if (do_write)
		begin
			o_s_axi_bvalid <= 1'b1;
			o_s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (i_s_axi_bready)
			o_s_axi_bvalid <= 1'b0;
	end

	// Configuration registers; reserved bits are masked off on write
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			port_en  <= RST_PORT_EN;
			buf_ctl  <= RST_BUF_CTL;
			port_map <= RST_PORT_MAP;
			chip_ctl <= RST_CHIP_CTL;
		end
		else if (do_write && w_strb[0])
		begin
			if (aw_addr == lpd_byte_addr(IDX_PORT_EN))
				port_en <= w_data[7:0] & MASK_PORT_EN;
			if (aw_addr == lpd_byte_addr(IDX_BUF_CTL))
				buf_ctl <= w_data[7:0] & MASK_BUF_CTL;
			if (aw_addr == lpd_byte_addr(IDX_PORT_MAP))
				port_map <= w_data[7:0] & MASK_PORT_MAP;
			if (aw_addr == lpd_byte_addr(IDX_CHIP_CTL))
				chip_ctl <= w_data[7:0] & MASK_CHIP_CTL;
		end
	end

	// Read channel
	always_comb
	begin
		rd_word = '0;
		rd_hit  = 1'b1;
		case (i_s_axi_araddr)
			lpd_byte_addr(IDX_PORT_EN):  rd_word = {24'h0, port_en};
			lpd_byte_addr(IDX_BUF_CTL):  rd_word = {24'h0, buf_ctl};
			lpd_byte_addr(IDX_PORT_MAP): rd_word = {24'h0, port_map};
			lpd_byte_addr(IDX_CHIP_CTL): rd_word = {24'h0, chip_ctl};
			lpd_byte_addr(IDX_STATUS):
				rd_word = {23'h0, o_draining, last_hit};
			default: rd_hit = 1'b0;
		endcase
	end

	assign o_s_axi_arready = ~o_s_axi_rvalid;

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata  <= '0;
			o_s_axi_rresp  <= RESP_OKAY;
		end
		else if (i_s_axi_arvalid && o_s_axi_arready)
		begin
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rdata  <= rd_word;
			o_s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (i_s_axi_rready)
			o_s_axi_rvalid <= 1'b0;
	end

	// Legacy range matching on the primary address phase
	assign io_cmd = (i_pri_cmd == CMD_IO_RD) || (i_pri_cmd == CMD_IO_WR);

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++)
		begin : g_range
			assign range_match[p] = (i_pri_addr[31:16] == 16'h0) &&
				(((i_pri_addr[15:0] >= PORT_LO[p]) &&
				(i_pri_addr[15:0] <= PORT_HI[p])) ||
				(PORT_HAS2[p] && (i_pri_addr[15:0] >= PORT2_LO[p]) &&
				(i_pri_addr[15:0] <= PORT2_HI[p])));
		end
	endgenerate

	// Enabled range hits, I/O commands only
	assign next_hit = range_match & port_en[NUM_PORTS-1:0] &
		{NUM_PORTS{io_cmd}};

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_port_hit      <= '0;
			o_fwd_secondary <= 1'b0;
			o_pri_claim     <= 1'b0;
			last_hit        <= '0;
		end
		else
		begin
			o_port_hit      <= i_pri_addr_vld ? next_hit : '0;
			// Forwarding needs both enable and map bits
			o_fwd_secondary <= i_pri_addr_vld &&
				|(next_hit & port_map[NUM_PORTS-1:0]);
			// Excluded legacy range overrides an I/O window
			o_pri_claim <= i_pri_addr_vld &&
				(|(next_hit & port_map[NUM_PORTS-1:0]) ||
				(i_io_window_hit &&
				~|(next_hit & ~port_map[NUM_PORTS-1:0])));
			if (i_pri_addr_vld)
				last_hit <= next_hit;
		end
	end

	// Burst control
	assign o_up_burst_multi = buf_ctl[BC_UP_MULTI] &
		~chip_ctl[CC_UP_BLOCK];
	assign o_dn_burst_en = buf_ctl[BC_DN_BURST];

	// Write posting control per interface
	genvar k;
	generate
		for (k = 0; k < NUM_IFC; k++)
		begin : g_post
			lpd_post_e st;
			logic      post;
			logic      last_q;

			// Bit k of the buffer byte governs interface k
			assign post = buf_ctl[k];
			assign o_post_en[k] = post;
			assign o_src_take[k] = i_src_valid[k] &&
				(post || (st == PST_TAKE));
			assign o_master_release[k] = post ?
				(o_src_take[k] && i_src_last[k]) :
				((st == PST_WAIT) && i_tgt_accept[k] && last_q);
			assign o_draining[k] = ~post && (st == PST_DRAIN) &&
				~i_buf_empty[k];

			always_ff @(posedge i_clk_sys or negedge i_nrst)
			begin
				if (!i_nrst)
				begin
					st     <= PST_DRAIN;
					last_q <= 1'b0;
				end
				else if (post)
					st <= PST_DRAIN;
				else
				begin
					case (st)
						PST_DRAIN:
							if (i_buf_empty[k])
								st <= PST_TAKE;
						PST_TAKE:
							if (i_src_valid[k])
							begin
								st     <= PST_WAIT;
								last_q <= i_src_last[k];
							end
						PST_WAIT:
							if (i_tgt_accept[k])
								st <= last_q ? PST_DRAIN : PST_TAKE;
						default:
							st <= PST_DRAIN;
					endcase
				end
			end

			no_take_drain_a: assert property (@(posedge i_clk_sys)
				disable iff (!i_nrst)
				(!post && st == PST_DRAIN) |-> !o_src_take[k])
				else $error("word taken before buffers drained");

			one_word_wait_a: assert property (@(posedge i_clk_sys)
				disable iff (!i_nrst)
				(!post && o_src_take[k] && !buf_ctl[k]) ##1 !post
				|-> !o_src_take[k])
				else $error("next word taken before target accept");

			release_accept_a: assert property (@(posedge i_clk_sys)
				disable iff (!i_nrst)
				(!post && o_master_release[k]) |-> i_tgt_accept[k])
				else $error("master released before final accept");
		end
	endgenerate

	enable_reserved_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		!port_en[7])
		else $error("reserved enable bit set");

	buffer_reserved_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		buf_ctl[7:5] == 3'h0 && !buf_ctl[3])
		else $error("reserved buffer bits set");

	par3_second_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(i_pri_addr_vld && io_cmd && i_pri_addr == 32'h0000067b &&
		port_en[6] && port_map[6]) |=> o_fwd_secondary && o_pri_claim)
		else $error("third parallel port range not decoded");

	par2_range_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(i_pri_addr_vld && io_cmd && i_pri_addr == 32'h0000037f &&
		port_en[5]) |=> o_port_hit[5])
		else $error("second parallel port range not decoded");

	par1_range_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(i_pri_addr_vld && io_cmd && i_pri_addr == 32'h000007bc &&
		port_en[4]) |=> o_port_hit[4])
		else $error("first parallel port range not decoded");

	ser4_range_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(i_pri_addr_vld && io_cmd && i_pri_addr == 32'h000002e8 &&
		port_en[3]) |=> o_port_hit[3])
		else $error("fourth serial port range not decoded");

	ser3_range_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(i_pri_addr_vld && io_cmd && i_pri_addr == 32'h000003ef &&
		port_en[2]) |=> o_port_hit[2])
		else $error("third serial port range not decoded");

	ser2_range_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(i_pri_addr_vld && io_cmd && i_pri_addr == 32'h000002f8 &&
		port_en[1]) |=> o_port_hit[1])
		else $error("second serial port range not decoded");

	ser1_range_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(i_pri_addr_vld && io_cmd && i_pri_addr == 32'h000003ff &&
		port_en[0] && !port_map[0]) |=> !o_fwd_secondary)
		else $error("first serial port forwarded without map bit");

	map_excludes_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(i_pri_addr_vld && io_cmd && i_pri_addr == 32'h000003f8 &&
		port_en[0] && !port_map[0]) |=> !o_pri_claim)
		else $error("excluded legacy range claimed");

	io_only_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(i_pri_addr_vld && !io_cmd) |=> o_port_hit == '0)
		else $error("legacy match on non-I/O command");

	up_block_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		chip_ctl[CC_UP_BLOCK] |-> !o_up_burst_multi)
		else $error("multi-line burst while blocked");

	dn_burst_wr_a: assert property (@(posedge i_clk_sys)
		disable iff (!i_nrst)
		(do_write && w_strb[0] &&
		aw_addr == lpd_byte_addr(IDX_BUF_CTL)) |=>
		o_dn_burst_en == $past(w_data[BC_DN_BURST]))
		else $error("downstream burst enable not written");

endmodule // lpd_ctrl

/* File: verilog/lpd_pkg.sv */
// Purpose: Constants for the legacy port decode and posting control block
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes:   Register byte address is four times the register index

package lpd_pkg;

	localparam int          ADDR_W        = 12;
	localparam int          NUM_PORTS     = 7;
	localparam int          NUM_IFC       = 2;

	// Register indexes
	localparam logic [7:0]  IDX_CHIP_CTL  = 8'h40;
	localparam logic [7:0]  IDX_PORT_EN   = 8'h58;
	localparam logic [7:0]  IDX_BUF_CTL   = 8'h59;
	localparam logic [7:0]  IDX_PORT_MAP  = 8'h5a;
	localparam logic [7:0]  IDX_STATUS    = 8'h5e;

	// Reset values and writable bit masks
	localparam logic [7:0]  RST_PORT_EN   = 8'h00;
	localparam logic [7:0]  RST_BUF_CTL   = 8'h07;
	localparam logic [7:0]  RST_PORT_MAP  = 8'h00;
	localparam logic [7:0]  RST_CHIP_CTL  = 8'h00;
	localparam logic [7:0]  MASK_PORT_EN  = 8'h7f;
	localparam logic [7:0]  MASK_BUF_CTL  = 8'h17;
	localparam logic [7:0]  MASK_PORT_MAP = 8'h7f;
	localparam logic [7:0]  MASK_CHIP_CTL = 8'h10;

	// Field positions
	localparam int          BC_UP_MULTI   = 4;
	localparam int          BC_DN_BURST   = 2;
	localparam int          BC_POST_PRI   = 1;
	localparam int          BC_POST_SEC   = 0;
	localparam int          CC_UP_BLOCK   = 4;

	// Bus commands taken part in legacy decode
	localparam logic [3:0]  CMD_IO_RD     = 4'h2;
	localparam logic [3:0]  CMD_IO_WR     = 4'h3;

	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// Legacy ranges, index = enable bit; serial ports, then parallel ports
	localparam logic [15:0] PORT_LO  [NUM_PORTS] = '{16'h03f8, 16'h02f8,
		16'h03e8, 16'h02e8, 16'h03bc, 16'h0378, 16'h0278};
	localparam logic [15:0] PORT_HI  [NUM_PORTS] = '{16'h03ff, 16'h02ff,
		16'h03ef, 16'h02ef, 16'h03bf, 16'h037f, 16'h027f};
	localparam logic [15:0] PORT2_LO [NUM_PORTS] = '{16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h07bc, 16'h0778, 16'h0678};
	localparam logic [15:0] PORT2_HI [NUM_PORTS] = '{16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h07bf, 16'h077b, 16'h067b};
	localparam logic [NUM_PORTS-1:0] PORT_HAS2 = 7'h70;

	typedef enum logic [2:0]
	{
		PST_DRAIN = 3'b001,
		PST_TAKE  = 3'b010,
		PST_WAIT  = 3'b100
	} lpd_post_e;

	function automatic logic [ADDR_W-1:0] lpd_byte_addr(logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction

endpackage

/* File: test/lpd_far_model.sv */
// Purpose: Far-side source master and target for both posting lanes
// Assumes: Bench starts a burst with a one-cycle start pulse
// Notes:   Target accepts a taken word i_delay+2 cycles later
`timescale 1ns/10ps
module lpd_far_model
(
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_nrst,
	// Bench commands
	input  wire logic [1:0] i_start,
	input  wire logic [3:0] i_words,
	input  wire logic [3:0] i_delay,
	input  wire logic [1:0] i_busy,
	// Bridge side
	input  wire logic [1:0] i_take,
	output logic [1:0]      o_src_valid,
	output logic [1:0]      o_src_last,
	output logic [1:0]      o_tgt_accept,
	output logic [1:0]      o_buf_empty
);
	logic [3:0] rem [2];
	logic [3:0] cnt [2];
	logic [1:0] pend;

	assign o_buf_empty = ~i_busy;

	// Offer is held until the bridge takes it
	always_comb
		for (int k = 0; k < 2; k++)
		begin
			o_src_valid[k] = rem[k] != 4'h0;
			o_src_last[k]  = rem[k] == 4'h1;
		end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
		if (!i_nrst)
		begin
			rem          <= '{4'h0, 4'h0};
			cnt          <= '{4'h0, 4'h0};
			pend         <= 2'h0;
			o_tgt_accept <= 2'h0;
		end
		else
			for (int k = 0; k < 2; k++)
			begin
				o_tgt_accept[k] <= 1'b0;
				if (i_start[k])
					rem[k] <= i_words;
				else if (i_take[k] && o_src_valid[k])
					rem[k] <= rem[k] - 4'h1;
				if (i_take[k] && o_src_valid[k])
				begin
					pend[k] <= 1'b1;
					cnt[k]  <= i_delay;
				end
				else if (pend[k] && cnt[k] == 4'h0)
				begin
					pend[k]         <= 1'b0;
					o_tgt_accept[k] <= 1'b1;
				end
				else if (pend[k])
					cnt[k] <= cnt[k] - 4'h1;
			end
endmodule // lpd_far_model

/* File: test/testbench.sv */
// Purpose: Self-checking bench for lpd_ctrl
// Assumes: AXI4-Lite master drives on rising edges
// Notes:   Handshakes sampled at the falling edge before use
`timescale 1ns/10ps
module testbench;
	import lpd_pkg::*;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        vld = 1'b0, win = 1'b0;
	logic [3:0]  cmd = 4'h0;
	logic [31:0] addr = 32'h0;
	logic        claim, fwd, up_multi, dn_burst;
	logic [6:0]  hit;
	logic [1:0]  empty, sval, slast, acc, post_en, take, rel, drain;
	logic [1:0]  start = 2'h0, busy = 2'h0;
	logic [3:0]  words = 4'h0, delay = 4'h0;
	int          error_cnt = 0, n_compared = 0;

	always #20 clk = ~clk;

	lpd_ctrl lpd_ctrl_i
	(
		.i_clk_sys(clk), .i_nrst(nrst),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .i_pri_addr_vld(vld),
		.i_pri_cmd(cmd), .i_pri_addr(addr), .i_io_window_hit(win),
		.o_pri_claim(claim), .o_fwd_secondary(fwd), .o_port_hit(hit),
		.o_up_burst_multi(up_multi), .o_dn_burst_en(dn_burst),
		.i_buf_empty(empty), .i_src_valid(sval), .i_src_last(slast),
		.i_tgt_accept(acc), .o_post_en(post_en), .o_src_take(take),
		.o_master_release(rel), .o_draining(drain)
	);

	lpd_far_model lpd_far_model_i
	(
		.i_clk_sys(clk), .i_nrst(nrst), .i_start(start),
		.i_words(words), .i_delay(delay), .i_busy(busy),
		.i_take(take), .o_src_valid(sval), .o_src_last(slast),
		.o_tgt_accept(acc), .o_buf_empty(empty)
	);

	task print_verdict;
		if (error_cnt == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic ta, tw, done;
		logic [1:0] r;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done)
		begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			done = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		cmp(r, er);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ta, done;
		logic [31:0] d;
		logic [1:0] r;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done)
		begin
			@(negedge clk);
			ta = arvalid && arready;
			done = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		cmp(d, ed);
		cmp(r, er);
	endtask

	task dec(input logic [3:0] c, input logic [15:0] a, input logic w,
		input logic ec, input logic ef, input logic [6:0] eh);
		@(posedge clk);
		vld <= 1'b1;
		cmd <= c;
		addr <= {16'h0, a};
		win <= w;
		@(posedge clk);
		vld <= 1'b0;
		@(negedge clk);
		cmp(claim, ec);
		cmp(fwd, ef);
		cmp(hit, eh);
	endtask

	// Runs one burst on lane k; unposted lanes start with buffers busy
	task burst(input int k, input logic [3:0] n, input logic [3:0] dl,
		input logic posted);
		int cyc, got;
		logic out, lastp, seen;
		got = 0;
		out = 1'b0;
		lastp = 1'b0;
		seen = 1'b0;
		@(posedge clk);
		busy[k] <= !posted;
		delay <= dl;
		words <= n;
		start[k] <= 1'b1;
		@(posedge clk);
		start[k] <= 1'b0;
		for (cyc = 0; cyc < 200 && !seen; cyc++)
		begin
			@(negedge clk);
			if (posted)
			begin
				cmp(take[k], sval[k]);
				cmp(rel[k], sval[k] && slast[k]);
			end
			else
			begin
				if (busy[k]) cmp(drain[k], 1'b1);
				if (busy[k] || out) cmp(take[k] && sval[k], 1'b0);
				cmp(rel[k], acc[k] && lastp);
				if (acc[k]) out = 1'b0;
			end
			if (take[k] && sval[k])
			begin
				got++;
				out = 1'b1;
				lastp = slast[k];
			end
			seen = rel[k];
			@(posedge clk);
			if (cyc == 3) busy[k] <= 1'b0;
		end
		cmp(got, n);
		cmp(seen, 1'b1);
	endtask

	initial
	begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		print_verdict;
	end

	initial
	begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rd(12'h160, 32'h0, RESP_OKAY);
		rd(12'h164, 32'h7, RESP_OKAY);
		cmp(post_en, 2'b11);
		cmp(dn_burst, 1'b1);
		cmp(up_multi, 1'b0);
		wr(12'h160, 8'hff, 4'hf, RESP_OKAY);
		rd(12'h160, 32'h7f, RESP_OKAY);
		wr(12'h164, 8'hff, 4'hf, RESP_OKAY);
		rd(12'h164, 32'h17, RESP_OKAY);
		cmp(up_multi, 1'b1);
		wr(12'h100, 8'h10, 4'hf, RESP_OKAY);
		cmp(up_multi, 1'b0);
		wr(12'h100, 8'h00, 4'hf, RESP_OKAY);
		wr(12'h164, 8'h13, 4'hf, RESP_OKAY);
		cmp(dn_burst, 1'b0);
		rd(12'h004, 32'h0, RESP_SLVERR);
		wr(12'h004, 8'h55, 4'hf, RESP_SLVERR);
		wr(12'h160, 8'h00, 4'he, RESP_OKAY);
		rd(12'h160, 32'h7f, RESP_OKAY);
		wr(12'h168, 8'h7f, 4'hf, RESP_OKAY);
		// Both ends of every range, and the word just above each first range
		for (int k = 0; k < NUM_PORTS; k++)
		begin
			logic [3:0] c;
			c = k[0] ? CMD_IO_RD : CMD_IO_WR;
			dec(c, PORT_LO[k], 1'b0, 1'b1, 1'b1, 7'h1 << k);
			dec(c, PORT_HI[k], 1'b0, 1'b1, 1'b1, 7'h1 << k);
			dec(c, PORT_HI[k] + 16'h1, 1'b0, 1'b0, 1'b0, 7'h0);
			if (PORT_HAS2[k])
			begin
				dec(c, PORT2_LO[k], 1'b0, 1'b1, 1'b1, 7'h1 << k);
				dec(c, PORT2_HI[k], 1'b0, 1'b1, 1'b1, 7'h1 << k);
			end
		end
		dec(4'h6, 16'h03f8, 1'b0, 1'b0, 1'b0, 7'h0);
		wr(12'h168, 8'h7e, 4'hf, RESP_OKAY);
		dec(CMD_IO_RD, 16'h03f8, 1'b1, 1'b0, 1'b0, 7'h01);
		dec(CMD_IO_WR, 16'h03ff, 1'b0, 1'b0, 1'b0, 7'h01);
		rd(12'h178, 32'h1, RESP_OKAY);
		dec(CMD_IO_RD, 16'h0500, 1'b1, 1'b1, 1'b0, 7'h0);
		wr(12'h160, 8'h00, 4'hf, RESP_OKAY);
		dec(CMD_IO_WR, 16'h02f8, 1'b0, 1'b0, 1'b0, 7'h0);
		burst(1, 4'h3, 4'h0, 1'b1);
		burst(0, 4'h4, 4'h2, 1'b1);
		// Buffers busy before posting is cleared, so the lane drains first
		busy[0] <= 1'b1;
		wr(12'h164, 8'h12, 4'hf, RESP_OKAY);
		cmp(post_en, 2'b10);
		burst(0, 4'h3, 4'h2, 1'b0);
		busy[1] <= 1'b1;
		wr(12'h164, 8'h11, 4'hf, RESP_OKAY);
		burst(1, 4'h1, 4'h0, 1'b0);
		// Lane is back in drain after its last word; keep buffers busy
		busy[1] <= 1'b1;
		burst(1, 4'h4, 4'h3, 1'b0);
		print_verdict;
	end
endmodule // testbench
